// >>> logic/sqr_regs.vh
// Constants of the segment sequencer
`ifndef SQR_REGS_VH
`define SQR_REGS_VH
// Sample tick period and clock period, in ns
`define SQR_TICK_NS     2000
`define SQR_CLK_NS      4
`define SQR_TICK_CYC    (`SQR_TICK_NS / `SQR_CLK_NS)
// Sequencer states
`define SQR_ST_IDLE     1'b0
`define SQR_ST_PLAY     1'b1
// Chain count that plays only the first sequence
`define SQR_ONE_SEQ     1
// Segment and sequence that start every pattern
`define SQR_FIRST       0
// FIFO depth
`define SQR_FIFO_DEPTH  16
`endif

// >>> logic/sqr_fifo.v
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/100ps
module sqr_fifo #(
  parameter W  = 16,
  parameter D  = 16,
  parameter AW = 4
) (
  input  wire          clk,
  input  wire          rst_n,
  input  wire          in_valid,
  output wire          in_ready,
  input  wire [W-1:0]  in_data,
  output wire          out_valid,
  input  wire          out_ready,
  output wire [W-1:0]  out_data
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0]   fill;
  wire         push;
  wire         pop;

  assign in_ready  = (fill != D[AW:0]);
  assign out_valid = (fill != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // ****************************************
  // Storage and pointers
  // ****************************************
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      fill   <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        fill <= fill + 1'b1;
      end else if (pop & ~push) begin
        fill <= fill - 1'b1;
      end
    end
  end
endmodule

// >>> logic/sqr_sequencer.v
// Segment sequencer of the waveform generator
`timescale 1ns/100ps
`include "sqr_regs.vh"
module sqr_sequencer #(
  parameter VAL_W   = 16,
  parameter SEQ_W   = 3,
  parameter SEG_W   = 5,
  parameter PAT_W   = 1,
  parameter HOLD_W  = 16,
  parameter REP_W   = 8,
  parameter LBL_W   = 8,
  parameter TRG_W   = 3,
  parameter TICK_CYC = `SQR_TICK_CYC
) (
  input  wire                clk,
  input  wire                rst_n,
  input  wire                wr_valid,
  output wire                wr_ready,
  input  wire [PAT_W-1:0]    wr_pat,
  input  wire [SEQ_W-1:0]    wr_seq,
  input  wire [SEG_W-1:0]    wr_seg,
  input  wire [VAL_W-1:0]    wr_value,
  input  wire                attr_wr,
  input  wire [PAT_W-1:0]    attr_pat,
  input  wire [SEQ_W-1:0]    attr_seq,
  input  wire [SEG_W:0]      attr_step_count,
  input  wire [SEQ_W-1:0]    attr_next,
  input  wire [REP_W-1:0]    attr_repeat,
  input  wire [HOLD_W-1:0]   attr_hold,
  input  wire                attr_mark_en,
  input  wire [SEG_W-1:0]    attr_mark_seg,
  input  wire                load_user_pattern,
  input  wire [PAT_W-1:0]    load_pat,
  input  wire [SEQ_W:0]      pattern_chain_count,
  input  wire [LBL_W-1:0]    load_label,
  input  wire                choose_pattern_by_label,
  input  wire [LBL_W-1:0]    choose_label,
  input  wire                start,
  input  wire                stop,
  input  wire                trig_route_en,
  input  wire [TRG_W-1:0]    trig_sel,
  output reg                 playing,
  output reg  [PAT_W-1:0]    cur_pat,
  output reg  [SEQ_W-1:0]    cur_seq,
  output reg  [SEG_W-1:0]    cur_seg,
  output reg                 sample_valid,
  output reg  [VAL_W-1:0]    sample_value,
  output reg                 marker_front,
  output reg  [(1<<TRG_W)-1:0] trig_out
);
  localparam NPAT  = 1 << PAT_W;
  localparam NSEQ  = 1 << SEQ_W;
  localparam AW    = PAT_W + SEQ_W + SEG_W;
  localparam SW    = PAT_W + SEQ_W;
  localparam FW    = AW + VAL_W;
  localparam TW    = 12;
  localparam [TW-1:0] TICK_LAST = TICK_CYC - 1;
  // First position and one-sequence chain, sized to their fields
  localparam [SEQ_W-1:0] SEQ_FIRST = `SQR_FIRST;
  localparam [SEG_W-1:0] SEG_FIRST = `SQR_FIRST;
  localparam [SEQ_W:0]   CHAIN_ONE = `SQR_ONE_SEQ;

  // ****************************************
  // Storage tables
  // ****************************************
  reg [VAL_W-1:0]  seg_table [0:(1<<AW)-1];
  reg [SEG_W:0]    steps_tab [0:(1<<SW)-1];
  reg [SEQ_W-1:0]  next_tab  [0:(1<<SW)-1];
  reg [REP_W-1:0]  rep_tab   [0:(1<<SW)-1];
  reg [HOLD_W-1:0] hold_tab  [0:(1<<SW)-1];
  reg              mken_tab  [0:(1<<SW)-1];
  reg [SEG_W-1:0]  mkseg_tab [0:(1<<SW)-1];
  reg [SEQ_W:0]    chain_cnt [0:NPAT-1];
  reg [LBL_W-1:0]  label_tab [0:NPAT-1];
  reg [NPAT-1:0]   pat_loaded;

  // ****************************************
  // Load path through the FIFO
  // ****************************************
  wire             fifo_valid;
  wire             fifo_ready;
  wire [FW-1:0]    fifo_data;
  wire [PAT_W-1:0] fifo_pat;

  assign fifo_pat = fifo_data[FW-1 -: PAT_W];
  // Writes into the pattern being played stall until playback stops or another pattern is loaded or chosen
  assign fifo_ready = ~(playing && (fifo_pat == cur_pat));

  sqr_fifo #(
    .W  (FW),
    .D  (`SQR_FIFO_DEPTH),
    .AW (4)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   ({wr_pat, wr_seq, wr_seg, wr_value}),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready),
    .out_data  (fifo_data)
  );

  always @(posedge clk) begin
    if (fifo_valid && fifo_ready) begin
      seg_table[fifo_data[FW-1:VAL_W]] <= fifo_data[VAL_W-1:0];
    end
    if (attr_wr) begin
      steps_tab[{attr_pat, attr_seq}] <= attr_step_count;
      next_tab[{attr_pat, attr_seq}]  <= attr_next;
      rep_tab[{attr_pat, attr_seq}]   <= attr_repeat;
      hold_tab[{attr_pat, attr_seq}]  <= attr_hold;
      mken_tab[{attr_pat, attr_seq}]  <= attr_mark_en;
      mkseg_tab[{attr_pat, attr_seq}] <= attr_mark_seg;
    end
  end

  // ****************************************
  // Pattern commit and label lookup
  // ****************************************
  wire load_ok;
  reg             label_hit;
  reg [PAT_W-1:0] label_pat;
  integer         i;

  assign load_ok = load_user_pattern && (pattern_chain_count >= CHAIN_ONE);

  always @* begin
    label_hit = 1'b0;
    label_pat = {PAT_W{1'b0}};
    for (i = 0; i < NPAT; i = i + 1) begin
      if (!label_hit && pat_loaded[i] && (label_tab[i] == choose_label)) begin
        label_hit = 1'b1;
        label_pat = i[PAT_W-1:0];
      end
    end
  end

  always @(posedge clk) begin
    if (load_ok) begin
      chain_cnt[load_pat] <= pattern_chain_count;
      label_tab[load_pat] <= load_label;
    end
  end

  // ****************************************
  // Sample tick divider
  // ****************************************
  reg [TW-1:0] tick_cnt;
  wire         tick;
  wire         restart;

  assign tick = (tick_cnt == TICK_LAST);
  // A restart by load or select begins a whole new tick
  assign restart = playing && !stop && (load_ok || (choose_pattern_by_label && label_hit));

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= {TW{1'b0}};
    end else if (!playing || tick || restart) begin
      tick_cnt <= {TW{1'b0}};
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
    end
  end

  // ****************************************
  // Current sequence attributes
  // ****************************************
  wire [SW-1:0]     cur_idx;
  wire [SEG_W:0]    cur_steps;
  wire [HOLD_W-1:0] cur_hold;
  wire [REP_W-1:0]  cur_rep;
  wire [SEQ_W-1:0]  cur_next;
  wire [SEQ_W:0]    cur_chain;
  wire [SEQ_W-1:0]  next_seq;
  wire              last_seg;

  assign cur_idx   = {cur_pat, cur_seq};
  assign cur_steps = steps_tab[cur_idx];
  assign cur_hold  = hold_tab[cur_idx];
  assign cur_rep   = rep_tab[cur_idx];
  assign cur_next  = next_tab[cur_idx];
  assign cur_chain = chain_cnt[cur_pat];
  assign last_seg  = ({1'b0, cur_seg} + 1'b1 >= cur_steps);
  // Successor link, forced to the first sequence for a one-sequence chain
  assign next_seq  = ((cur_chain == CHAIN_ONE) || ({1'b0, cur_next} >= cur_chain)) ?
                     SEQ_FIRST : cur_next;

  // ****************************************
  // Playback state machine
  // ****************************************
  reg              state;
  reg [HOLD_W-1:0] hold_cnt;
  reg [REP_W-1:0]  rep_cnt;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= `SQR_ST_IDLE;
      playing    <= 1'b0;
      cur_pat    <= {PAT_W{1'b0}};
      cur_seq    <= {SEQ_W{1'b0}};
      cur_seg    <= {SEG_W{1'b0}};
      hold_cnt   <= {HOLD_W{1'b0}};
      rep_cnt    <= {REP_W{1'b0}};
      pat_loaded <= {NPAT{1'b0}};
    end else begin
      if (load_ok) begin
        pat_loaded[load_pat] <= 1'b1;
      end
      case (state)
        `SQR_ST_IDLE: begin
          if (load_ok) begin
            cur_pat <= load_pat;
          end else if (choose_pattern_by_label && label_hit) begin
            cur_pat <= label_pat;
          end
          if (start && !load_ok && pat_loaded[cur_pat]) begin
            state    <= `SQR_ST_PLAY;
            playing  <= 1'b1;
            cur_seq  <= SEQ_FIRST;
            cur_seg  <= SEG_FIRST;
            hold_cnt <= {HOLD_W{1'b0}};
            rep_cnt  <= {REP_W{1'b0}};
          end
        end
        `SQR_ST_PLAY: begin
          if (stop) begin
            state   <= `SQR_ST_IDLE;
            playing <= 1'b0;
          end else if (load_ok || (choose_pattern_by_label && label_hit)) begin
            cur_pat  <= load_ok ? load_pat : label_pat;
            cur_seq  <= SEQ_FIRST;
            cur_seg  <= SEG_FIRST;
            hold_cnt <= {HOLD_W{1'b0}};
            rep_cnt  <= {REP_W{1'b0}};
          end else if (tick) begin
            if (hold_cnt != cur_hold) begin
              hold_cnt <= hold_cnt + 1'b1;
            end else begin
              hold_cnt <= {HOLD_W{1'b0}};
              if (!last_seg) begin
                cur_seg <= cur_seg + 1'b1;
              end else begin
                cur_seg <= SEG_FIRST;
                if (rep_cnt != cur_rep) begin
                  rep_cnt <= rep_cnt + 1'b1;
                end else begin
                  rep_cnt <= {REP_W{1'b0}};
                  cur_seq <= next_seq;
                end
              end
            end
          end
        end
        default: begin
          state   <= `SQR_ST_IDLE;
          playing <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Sample and marker outputs
  // ****************************************
  wire mark_now;

  assign mark_now = playing && (cur_seq != SEQ_FIRST) && mken_tab[cur_idx] &&
                    (cur_seg == mkseg_tab[cur_idx]);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_valid <= 1'b0;
      sample_value <= {VAL_W{1'b0}};
      marker_front <= 1'b0;
      trig_out     <= {(1<<TRG_W){1'b0}};
    end else begin
      sample_valid <= playing;
      sample_value <= playing ? seg_table[{cur_pat, cur_seq, cur_seg}] : {VAL_W{1'b0}};
      marker_front <= mark_now;
      trig_out     <= (mark_now && trig_route_en) ? ({{((1<<TRG_W)-1){1'b0}}, 1'b1} << trig_sel) :
                      {(1<<TRG_W){1'b0}};
    end
  end
endmodule

// >>> tb/sqr_seq_sva.sv
// Checker of the segment sequencer
`timescale 1ns/100ps
module sqr_seq_sva #(
  parameter TICK_CYC = 500
) (
  input wire        clk,
  input wire        rst_n,
  input wire        start,
  input wire        stop,
  input wire        load_user_pattern,
  input wire        choose_pattern_by_label,
  input wire        trig_route_en,
  input wire [2:0]  trig_sel,
  input wire        playing,
  input wire [2:0]  cur_seq,
  input wire [4:0]  cur_seg,
  input wire        sample_valid,
  input wire [15:0] sample_value,
  input wire        marker_front,
  input wire [7:0]  trig_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ****************************************
  // Segment age tracking
  // ****************************************
  reg  [7:0]  pos_q;
  reg  [31:0] age;
  reg         clean;
  reg         ctl_q;
  wire        moved = {cur_seq, cur_seg} != pos_q;
  wire        ctl   = start | stop | load_user_pattern | choose_pattern_by_label | !playing;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_q <= 8'h00;
      age   <= 32'h0;
      clean <= 1'b0;
      ctl_q <= 1'b0;
    end else begin
      pos_q <= {cur_seq, cur_seg};
      age   <= moved ? 32'h1 : age + 32'h1;
      ctl_q <= ctl;
      clean <= (ctl | ctl_q) ? 1'b0 : (moved ? 1'b1 : clean);
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  sequence s_begin;
    $rose(playing);
  endsequence
  a_seg_whole_ticks: assert property (moved && clean |-> age >= TICK_CYC && age % TICK_CYC == 0)
    else $error("segment held for a partial tick");
  a_play_needs_start: assert property (s_begin |-> $past(start))
    else $error("playback began without start");
  a_begin_first_seg: assert property (s_begin |-> (cur_seq == 3'h0 && cur_seg == 5'h00) ##1 sample_valid)
    else $error("playback did not begin at first segment");
  a_valid_stops: assert property ($fell(playing) |=> !sample_valid)
    else $error("sample valid after playback ended");
  a_idle_quiet: assert property (!playing && !$past(playing) |-> !sample_valid && sample_value == 16'h0000 && !marker_front)
    else $error("output active while idle");
  a_mark_seq_zero: assert property (cur_seq == 3'h0 && $past(cur_seq) == 3'h0 && $past(cur_seq, 2) == 3'h0 |-> !marker_front)
    else $error("marker in sequence zero");
  a_trig_copy: assert property (trig_route_en && $past(trig_route_en) && $stable(trig_sel) |-> trig_out == ({7'h00, marker_front} << trig_sel))
    else $error("trigger line does not copy marker");
  a_no_route: assert property (!trig_route_en && !$past(trig_route_en) |-> trig_out == 8'h00)
    else $error("trigger driven while routing off");
endmodule
bind sqr_sequencer sqr_seq_sva #(.TICK_CYC(TICK_CYC)) chk_u (
  .clk(clk), .rst_n(rst_n), .start(start), .stop(stop), .load_user_pattern(load_user_pattern),
  .choose_pattern_by_label(choose_pattern_by_label), .trig_route_en(trig_route_en), .trig_sel(trig_sel),
  .playing(playing), .cur_seq(cur_seq), .cur_seg(cur_seg), .sample_valid(sample_valid),
  .sample_value(sample_value), .marker_front(marker_front), .trig_out(trig_out)
);

// >>> tb/tb_top.sv
// Testbench of the segment sequencer
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  reg         clk = 0, rst_n = 0, wr_valid = 0, attr_wr = 0, attr_mark_en = 0;
  reg         load_user_pattern = 0, choose_pattern_by_label = 0, start = 0, stop = 0, trig_route_en = 0;
  reg  [0:0]  wr_pat = 0, attr_pat = 0, load_pat = 0;
  reg  [2:0]  wr_seq = 0, attr_seq = 0, attr_next = 0, trig_sel = 3'h5;
  reg  [4:0]  wr_seg = 0, attr_mark_seg = 0;
  reg  [5:0]  attr_step_count = 0;
  reg  [3:0]  pattern_chain_count = 0;
  reg  [7:0]  attr_repeat = 0, load_label = 0, choose_label = 0;
  reg  [15:0] wr_value = 0, attr_hold = 0;
  wire        wr_ready, playing, sample_valid, marker_front;
  wire [0:0]  cur_pat;
  wire [2:0]  cur_seq;
  wire [4:0]  cur_seg;
  wire [15:0] sample_value;
  wire [7:0]  trig_out;
  integer     n_mismatch = 0, n_tests = 0, i, c;
  sqr_sequencer #(.TICK_CYC(4)) dut_u (
    .clk(clk), .rst_n(rst_n), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_pat(wr_pat), .wr_seq(wr_seq),
    .wr_seg(wr_seg), .wr_value(wr_value), .attr_wr(attr_wr), .attr_pat(attr_pat), .attr_seq(attr_seq),
    .attr_step_count(attr_step_count), .attr_next(attr_next), .attr_repeat(attr_repeat), .attr_hold(attr_hold),
    .attr_mark_en(attr_mark_en), .attr_mark_seg(attr_mark_seg), .load_user_pattern(load_user_pattern),
    .load_pat(load_pat), .pattern_chain_count(pattern_chain_count), .load_label(load_label),
    .choose_pattern_by_label(choose_pattern_by_label), .choose_label(choose_label), .start(start), .stop(stop),
    .trig_route_en(trig_route_en), .trig_sel(trig_sel), .playing(playing), .cur_pat(cur_pat), .cur_seq(cur_seq),
    .cur_seg(cur_seg), .sample_valid(sample_valid), .sample_value(sample_value), .marker_front(marker_front),
    .trig_out(trig_out)
  );
  initial forever #2 clk = ~clk;
  // ****************************************
  // Access tasks
  // ****************************************
  task print_verdict;
    begin
      $display("mismatches %0d, comparisons %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  task wr(input p, input [2:0] s, input [4:0] g, input [15:0] v);
    begin
      @(posedge clk);
      {wr_valid, wr_pat, wr_seq, wr_seg, wr_value} <= {1'b1, p, s, g, v};
      c = 0;
      @(negedge clk);
      while (!wr_ready && c < 5000) begin c++; @(negedge clk); end
      if (c == 5000) begin n_mismatch++; print_verdict; end
    end
  endtask
  task wr_done;
    @(posedge clk) wr_valid <= 0;
  endtask
  task attr(input p, input [2:0] s, input [5:0] n, input [2:0] nx, input [7:0] r, input [15:0] h, input m, input [4:0] ms);
    begin
      @(posedge clk);
      {attr_wr, attr_pat, attr_seq, attr_step_count, attr_next} <= {1'b1, p, s, n, nx};
      {attr_repeat, attr_hold, attr_mark_en, attr_mark_seg} <= {r, h, m, ms};
      @(posedge clk) attr_wr <= 0;
    end
  endtask
  task load(input p, input [3:0] n, input [7:0] l);
    begin
      @(posedge clk);
      {load_user_pattern, load_pat, pattern_chain_count, load_label} <= {1'b1, p, n, l};
      @(posedge clk) load_user_pattern <= 0;
    end
  endtask
  task choose(input [7:0] l);
    begin
      @(posedge clk);
      {choose_pattern_by_label, choose_label} <= {1'b1, l};
      @(posedge clk) choose_pattern_by_label <= 0;
      @(negedge clk);
    end
  endtask
  task pulse(input k);
    begin
      @(posedge clk) if (k) stop <= 1; else start <= 1;
      @(posedge clk) {start, stop} <= 2'b00;
      repeat (2) @(negedge clk);
    end
  endtask
  // Measures how long a value stands, checking marker and trigger on its third cycle
  task run(input [15:0] v, input integer n, input m, input integer wmax);
    integer w;
    begin
      w = 0;
      while (sample_value !== v && w < wmax) begin w++; @(negedge clk); end
      if (sample_value !== v) begin n_mismatch++; print_verdict; end
      c = 0;
      while (sample_value === v && c < 400) begin
        if (c == 2) `CHK(marker_front, m)
        if (c == 2) `CHK(trig_out, m ? 8'h20 : 8'h00)
        c++;
        @(negedge clk);
      end
      if (c == 400) begin n_mismatch++; print_verdict; end
      `CHK(c, n)
    end
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1;
    @(negedge clk);
    `CHK({playing, sample_valid, marker_front, trig_out, sample_value}, 27'h0)
    pulse(0);
    `CHK(playing, 1'b0)
    load(0, 4'h0, 8'hA5);
    pulse(0);
    `CHK(playing, 1'b0)
    for (i = 0; i < 4; i++) wr(0, 0, i, 16'h0010 + i);
    for (i = 0; i < 3; i++) wr(0, 1, i, 16'h0020 + i);
    wr_done;
    attr(0, 0, 6'h03, 3'h1, 8'h00, 16'h0000, 1, 5'h01);
    attr(0, 1, 6'h02, 3'h0, 8'h01, 16'h0001, 1, 5'h01);
    repeat (20) @(posedge clk);
    load(0, 4'h2, 8'hA5);
    @(posedge clk) trig_route_en <= 1;
    @(negedge clk);
    `CHK(playing, 1'b0)
    pulse(0);
    run(16'h0010, 4, 0, 3000);
    run(16'h0011, 4, 0, 0);
    run(16'h0012, 4, 0, 0);
    for (i = 0; i < 2; i++) begin
      run(16'h0020, 8, 0, 0);
      run(16'h0021, 8, 1, 0);
    end
    run(16'h0010, 4, 0, 0);
    wr(1, 0, 0, 16'h0040);
    wr(1, 0, 1, 16'h0041);
    wr(1, 1, 0, 16'h0050);
    wr_done;
    attr(1, 0, 6'h02, 3'h1, 8'h00, 16'd49, 0, 5'h00);
    attr(1, 1, 6'h01, 3'h0, 8'h00, 16'h0000, 0, 5'h00);
    repeat (20) @(posedge clk);
    load(1, 4'h1, 8'h3C);
    @(negedge clk);
    `CHK(cur_pat, 1'b1)
    run(16'h0040, 200, 0, 100);
    run(16'h0041, 200, 0, 0);
    run(16'h0040, 200, 0, 0);
    for (i = 0; i < 16; i++) wr(1, 2, i, i);
    wr_done;
    @(negedge clk);
    `CHK(wr_ready, 1'b0)
    choose(8'hA5);
    `CHK(cur_pat, 1'b0)
    run(16'h0010, 4, 0, 100);
    c = 0;
    while (!wr_ready && c < 100) begin c++; @(negedge clk); end
    if (c == 100) begin n_mismatch++; print_verdict; end
    `CHK(wr_ready, 1'b1)
    choose(8'h77);
    `CHK(cur_pat, 1'b0)
    pulse(1);
    `CHK({playing, sample_value}, 17'h0)
    print_verdict;
  end
endmodule
